// ==== inc/pmcp_pkg.sv ====
// Shared constants, types and decode helpers for the program memory
// code protection block.
// Assumes a byte-addressed 22-bit table address space.
package pmcp_pkg;

    // ******************************************************
    // Address map
    // ******************************************************
    localparam int          ADDR_W       = 22;
    localparam int          DATA_W       = 8;
    localparam logic [21:0] BOOT_1K_END  = 22'h0003ff;
    localparam logic [21:0] BOOT_2K_END  = 22'h0007ff;
    localparam logic [21:0] BLK_A_BASE   = 22'h001000;
    localparam logic [21:0] BLK_B_BASE   = 22'h002000;
    localparam logic [21:0] USER_END     = 22'h003fff;
    localparam logic [21:0] ID_BASE      = 22'h200000;
    localparam logic [21:0] ID_END       = 22'h200007;
    localparam logic [21:0] CFG_EXT_LO   = 22'h300008;
    localparam logic [21:0] CFG_EXT_HI   = 22'h300009;
    localparam logic [21:0] CFG_WRI_LO   = 22'h30000a;
    localparam logic [21:0] CFG_WRI_HI   = 22'h30000b;
    localparam logic [21:0] CFG_RDI_LO   = 22'h30000c;
    localparam logic [21:0] CFG_RDI_HI   = 22'h30000d;
    localparam logic [21:0] DEVID_LO     = 22'h3ffffe;
    localparam logic [21:0] DEVID_HI     = 22'h3fffff;
    // Program memory held back for the background debugger
    localparam logic [21:0] DBG_PGM_BYTES = 22'h000200;
    localparam logic [21:0] DBG_RSV_BASE  = USER_END - DBG_PGM_BYTES + 22'h000001;

    // ******************************************************
    // Field positions and reset values
    // ******************************************************
    localparam int   FLD_BLK_A = 0;
    localparam int   FLD_BLK_B = 1;
    localparam int   FLD_BOOT  = 6;
    localparam int   FLD_CONFIG_WRITE_PROTECT_BIT  = 5;
    localparam int   IDX_BOOT  = 0;
    localparam int   IDX_A     = 1;
    localparam int   IDX_B     = 2;
    localparam logic [2:0] PROT_RST = 3'h7;
    localparam logic       CONFIG_WRITE_PROTECT_BIT_RST = 1'b1;

    typedef enum logic [2:0] {
        RG_BOOT, RG_A, RG_B, RG_UNIMP, RG_ID, RG_CFG, RG_DEVID
    } pmcp_region_t;

    // Region of a table address; boot size chosen by strap
    function automatic pmcp_region_t pmcp_region_of(input logic [21:0] a,
                                                    input logic        boot2k);
        pmcp_region_t r;
        r = RG_UNIMP;
        if (a <= (boot2k ? BOOT_2K_END : BOOT_1K_END)) r = RG_BOOT;
        else if (a < BLK_B_BASE) r = RG_A;
        else if (a <= USER_END) r = RG_B;
        else if (a >= ID_BASE && a <= ID_END) r = RG_ID;
        else if (a >= CFG_EXT_LO && a <= CFG_RDI_HI) r = RG_CFG;
        else if (a >= DEVID_LO) r = RG_DEVID;
        return r;
    endfunction

    // Index of a user block into the protection trios
    function automatic logic [1:0] pmcp_blk_idx(input pmcp_region_t r);
        logic [1:0] i;
        i = 2'(IDX_BOOT);
        if (r == RG_A) i = 2'(IDX_A);
        if (r == RG_B) i = 2'(IDX_B);
        return i;
    endfunction

endpackage

// ==== hdl/pmcp_id_mem.sv ====
// Eight-byte user identification store with a registered read port.
// Assumes the caller has already decided the access is allowed.
`timescale 1ns/1ps
`default_nettype none
module pmcp_id_mem
    import pmcp_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       en_in,
    input  wire logic       we_in,
    input  wire logic [2:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out
);

    logic [7:0] mem_r [8];
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // Read data always follows the addressed byte
    always_comb begin
        rdata_nxt = mem_r[addr_in];
    end

    // Array holds no reset: contents are nonvolatile in the real part
    always_ff @(posedge clk_in) begin
        if (en_in && we_in) begin
            mem_r[addr_in] <= wdata_in;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_r <= 8'h00;
        end else if (en_in) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_out = rdata_r;

endmodule
`default_nettype wire

// ==== hdl/pmcp_guard.sv ====
// Access permission check for one table or programmer access.
// Assumes regions are decoded by the caller; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module pmcp_guard
    import pmcp_pkg::*;
(
    input  wire pmcp_region_t tgt_in,
    input  wire pmcp_region_t pc_in,
    input  wire logic [21:0]  addr_in,
    input  wire logic         ext_in,
    input  wire logic         rd_in,
    input  wire logic [2:0]   ext_inh_in,
    input  wire logic [2:0]   wr_inh_in,
    input  wire logic [2:0]   rd_iso_in,
    input  wire logic         config_write_protect_bit_in,
    input  wire logic         dbg_on_in,
    output logic              allow_out
);

    logic [1:0] bi;
    logic       user;
    logic       dbg_hit;

    // Decide per region and per requester
    always_comb begin
        bi      = pmcp_blk_idx(tgt_in);
        user    = (tgt_in == RG_BOOT) || (tgt_in == RG_A) || (tgt_in == RG_B);
        dbg_hit = dbg_on_in && addr_in >= DBG_RSV_BASE && addr_in <= USER_END;
        allow_out = 1'b0;
        if (user && ext_in) begin
            allow_out = ext_inh_in[bi];
        end else if (user && rd_in) begin
            // Own-block reads pass regardless of isolation
            allow_out = rd_iso_in[bi] || (pc_in == tgt_in);
        end else if (user) begin
            allow_out = wr_inh_in[bi] && !dbg_hit;
        end else begin
            case (tgt_in)
                RG_ID:    allow_out = 1'b1;
                RG_CFG:   allow_out = rd_in || ext_in || config_write_protect_bit_in;
                RG_DEVID: allow_out = rd_in;
                RG_UNIMP: allow_out = rd_in;
                default:  allow_out = 1'b0;
            endcase
        end
    end

endmodule
`default_nettype wire

// ==== hdl/pmcp_top.sv ====
// Program memory code protection: gates table and programmer accesses
// to program flash and configuration bytes; identification bytes are never refused.
// Assumes a flash array that returns read data in the same cycle as the
// read strobe, and a programmer that only drives its port in PGM mode.
`timescale 1ns/1ps
`default_nettype none
module pmcp_top
    import pmcp_pkg::*;
#(
    parameter logic [15:0] DEV_ID = 16'h5a3c  // Arbitrary value
)(
    input  wire logic        CLOCK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        CLK_EN_IN,
    input  wire logic        BOOT_2K_IN,
    input  wire logic        DEBUG_EN_B_IN,
    input  wire logic        TBL_RD_IN,
    input  wire logic        TBL_WR_IN,
    input  wire logic [21:0] TBL_ADDR_IN,
    input  wire logic [21:0] TBL_PC_IN,
    input  wire logic [7:0]  TBL_WDATA_IN,
    input  wire logic        PGM_MODE_IN,
    input  wire logic        PGM_RD_IN,
    input  wire logic        PGM_WR_IN,
    input  wire logic [21:0] PGM_ADDR_IN,
    input  wire logic [7:0]  PGM_WDATA_IN,
    input  wire logic        PGM_CHIP_ERASE_IN,
    input  wire logic        PGM_BLOCK_ERASE_IN,
    input  wire logic [1:0]  PGM_ERASE_BLK_IN,
    input  wire logic [7:0]  FLASH_RDATA_IN,
    output logic      [21:0] FLASH_ADDR_OUT,
    output logic             FLASH_RD_OUT,
    output logic             FLASH_WR_OUT,
    output logic      [7:0]  FLASH_WDATA_OUT,
    output logic             FLASH_ERASE_ALL_OUT,
    output logic             FLASH_ERASE_BLK_OUT,
    output logic      [1:0]  FLASH_ERASE_SEL_OUT,
    output logic      [7:0]  RDATA_OUT,
    output logic             DONE_OUT,
    output logic             REFUSED_OUT,
    output logic             DBG_RESERVE_OUT
);

    // ******************************************************
    // Request selection and decode
    // ******************************************************
    logic         ext;
    logic         rq_rd;
    logic         rq_wr;
    logic [21:0]  rq_addr;
    logic [7:0]   rq_wdata;
    pmcp_region_t tgt;
    pmcp_region_t pcr;
    logic         allow;
    logic         user;
    logic         chip_er;
    logic         blk_er;

    // Programmer owns the port in PGM mode; read wins over write
    always_comb begin
        ext      = PGM_MODE_IN;
        rq_rd    = ext ? PGM_RD_IN : TBL_RD_IN;
        rq_wr    = (ext ? PGM_WR_IN : TBL_WR_IN) && !rq_rd;
        rq_addr  = ext ? PGM_ADDR_IN : TBL_ADDR_IN;
        rq_wdata = ext ? PGM_WDATA_IN : TBL_WDATA_IN;
        tgt      = pmcp_region_of(rq_addr, BOOT_2K_IN);
        pcr      = pmcp_region_of(TBL_PC_IN, BOOT_2K_IN);
        user     = tgt == RG_BOOT || tgt == RG_A || tgt == RG_B;
        // Erase pins only live in PGM mode
        chip_er  = ext && PGM_CHIP_ERASE_IN;
        blk_er   = ext && PGM_BLOCK_ERASE_IN && !chip_er;
    end

    // ******************************************************
    // Protection bits
    // ******************************************************
    logic [2:0] ext_inh_r, ext_inh_nxt;
    logic [2:0] wr_inh_r, wr_inh_nxt;
    logic [2:0] rd_iso_r, rd_iso_nxt;
    logic       config_write_protect_bit_r, config_write_protect_bit_nxt;
    logic       cfg_wr;

    pmcp_guard u_guard (
        .tgt_in     (tgt),
        .pc_in      (pcr),
        .addr_in    (rq_addr),
        .ext_in     (ext),
        .rd_in      (rq_rd),
        .ext_inh_in (ext_inh_r),
        .wr_inh_in  (wr_inh_r),
        .rd_iso_in  (rd_iso_r),
        .config_write_protect_bit_in    (config_write_protect_bit_r),
        .dbg_on_in  (DBG_RESERVE_OUT),
        .allow_out  (allow)
    );

    // Writes AND into the bits so a zero never returns to one
    always_comb begin
        ext_inh_nxt = ext_inh_r;
        wr_inh_nxt  = wr_inh_r;
        rd_iso_nxt  = rd_iso_r;
        config_write_protect_bit_nxt    = config_write_protect_bit_r;
        cfg_wr      = rq_wr && allow && tgt == RG_CFG;
        if (cfg_wr) begin
            case (rq_addr)
                CFG_EXT_LO: ext_inh_nxt[2:1] = ext_inh_r[2:1]
                                & rq_wdata[FLD_BLK_B:FLD_BLK_A];
                CFG_EXT_HI: ext_inh_nxt[IDX_BOOT] = ext_inh_r[IDX_BOOT]
                                & rq_wdata[FLD_BOOT];
                CFG_WRI_LO: wr_inh_nxt[2:1] = wr_inh_r[2:1]
                                & rq_wdata[FLD_BLK_B:FLD_BLK_A];
                CFG_WRI_HI: begin
                    wr_inh_nxt[IDX_BOOT] = wr_inh_r[IDX_BOOT] & rq_wdata[FLD_BOOT];
                    // Firmware cannot touch the write protect bit
                    if (ext) begin
                        config_write_protect_bit_nxt = config_write_protect_bit_r & rq_wdata[FLD_CONFIG_WRITE_PROTECT_BIT];
                    end
                end
                CFG_RDI_LO: rd_iso_nxt[2:1] = rd_iso_r[2:1]
                                & rq_wdata[FLD_BLK_B:FLD_BLK_A];
                CFG_RDI_HI: rd_iso_nxt[IDX_BOOT] = rd_iso_r[IDX_BOOT]
                                & rq_wdata[FLD_BOOT];
                default: ;
            endcase
        end
        // Erase is the only way back to one
        if (chip_er) begin
            ext_inh_nxt = PROT_RST;
            wr_inh_nxt  = PROT_RST;
            rd_iso_nxt  = PROT_RST;
            config_write_protect_bit_nxt    = CONFIG_WRITE_PROTECT_BIT_RST;
        end else if (blk_er) begin
            ext_inh_nxt[PGM_ERASE_BLK_IN] = 1'b1;
            wr_inh_nxt[PGM_ERASE_BLK_IN]  = 1'b1;
            rd_iso_nxt[PGM_ERASE_BLK_IN]  = 1'b1;
        end
    end

    // Reset models the erased state; nonvolatility lives outside
    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            ext_inh_r <= PROT_RST;
            wr_inh_r  <= PROT_RST;
            rd_iso_r  <= PROT_RST;
            config_write_protect_bit_r    <= CONFIG_WRITE_PROTECT_BIT_RST;
        end else if (CLK_EN_IN) begin
            ext_inh_r <= ext_inh_nxt;
            wr_inh_r  <= wr_inh_nxt;
            rd_iso_r  <= rd_iso_nxt;
            config_write_protect_bit_r    <= config_write_protect_bit_nxt;
        end
    end

    // ******************************************************
    // Stage one: flash strobes and captured read bytes
    // ******************************************************
    logic         s1_vld_r, s1_vld_nxt;
    logic         s1_ok_r, s1_ok_nxt;
    pmcp_region_t s1_rg_r, s1_rg_nxt;
    logic [7:0]   s1_byte_r, s1_byte_nxt;
    logic [21:0]  fa_r, fa_nxt;
    logic         frd_r, frd_nxt;
    logic         fwr_r, fwr_nxt;
    logic [7:0]   fwd_r, fwd_nxt;
    logic         fea_r, fea_nxt;
    logic         feb_r, feb_nxt;
    logic [1:0]   fes_r, fes_nxt;
    logic         dbg_r, dbg_nxt;
    logic [7:0]   id_rdata;

    // Unimplemented config bits read as zero
    always_comb begin
        s1_vld_nxt  = rq_rd || rq_wr;
        s1_ok_nxt   = allow;
        s1_rg_nxt   = tgt;
        s1_byte_nxt = 8'h00;
        case (rq_addr)
            CFG_EXT_LO: s1_byte_nxt = {6'h00, ext_inh_r[2:1]};
            CFG_EXT_HI: s1_byte_nxt = {1'b0, ext_inh_r[IDX_BOOT], 6'h00};
            CFG_WRI_LO: s1_byte_nxt = {6'h00, wr_inh_r[2:1]};
            CFG_WRI_HI: s1_byte_nxt = {1'b0, wr_inh_r[IDX_BOOT], config_write_protect_bit_r, 5'h00};
            CFG_RDI_LO: s1_byte_nxt = {6'h00, rd_iso_r[2:1]};
            CFG_RDI_HI: s1_byte_nxt = {1'b0, rd_iso_r[IDX_BOOT], 6'h00};
            DEVID_LO:   s1_byte_nxt = DEV_ID[7:0];
            DEVID_HI:   s1_byte_nxt = DEV_ID[15:8];
            default: ;
        endcase
        // Refused flash accesses never reach the array
        fa_nxt  = s1_vld_nxt ? rq_addr : fa_r;
        frd_nxt = rq_rd && allow && user;
        fwr_nxt = rq_wr && allow && user;
        fwd_nxt = rq_wr ? rq_wdata : fwd_r;
        fea_nxt = chip_er;
        feb_nxt = blk_er;
        fes_nxt = blk_er ? PGM_ERASE_BLK_IN : fes_r;
        dbg_nxt = !DEBUG_EN_B_IN;
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            s1_vld_r  <= 1'b0;
            s1_ok_r   <= 1'b0;
            s1_rg_r   <= RG_UNIMP;
            s1_byte_r <= 8'h00;
            fa_r      <= 22'h000000;
            frd_r     <= 1'b0;
            fwr_r     <= 1'b0;
            fwd_r     <= 8'h00;
            fea_r     <= 1'b0;
            feb_r     <= 1'b0;
            fes_r     <= 2'h0;
            dbg_r     <= 1'b0;
        end else if (CLK_EN_IN) begin
            s1_vld_r  <= s1_vld_nxt;
            s1_ok_r   <= s1_ok_nxt;
            s1_rg_r   <= s1_rg_nxt;
            s1_byte_r <= s1_byte_nxt;
            fa_r      <= fa_nxt;
            frd_r     <= frd_nxt;
            fwr_r     <= fwr_nxt;
            fwd_r     <= fwd_nxt;
            fea_r     <= fea_nxt;
            feb_r     <= feb_nxt;
            fes_r     <= fes_nxt;
            dbg_r     <= dbg_nxt;
        end
    end

    // ID bytes answer through their own registered port
    pmcp_id_mem u_id (
        .clk_in    (CLOCK_IN),
        .rst_b_in  (RST_B_IN),
        .en_in     (CLK_EN_IN),
        .we_in     (rq_wr && tgt == RG_ID),
        .addr_in   (rq_addr[2:0]),
        .wdata_in  (rq_wdata),
        .rdata_out (id_rdata)
    );

    // ******************************************************
    // Stage two: answer
    // ******************************************************
    logic [7:0] rd_r, rd_nxt;
    logic       done_r, done_nxt;
    logic       ref_r, ref_nxt;

    // Refused reads answer zeros, never stale array data
    always_comb begin
        rd_nxt = 8'h00;
        if (s1_vld_r && s1_ok_r) begin
            case (s1_rg_r)
                RG_BOOT, RG_A, RG_B: rd_nxt = FLASH_RDATA_IN;
                RG_ID:               rd_nxt = id_rdata;
                RG_CFG, RG_DEVID:    rd_nxt = s1_byte_r;
                default:             rd_nxt = 8'h00;
            endcase
        end
        done_nxt = s1_vld_r;
        ref_nxt  = s1_vld_r && !s1_ok_r;
    end

    always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
        if (!RST_B_IN) begin
            rd_r   <= 8'h00;
            done_r <= 1'b0;
            ref_r  <= 1'b0;
        end else if (CLK_EN_IN) begin
            rd_r   <= rd_nxt;
            done_r <= done_nxt;
            ref_r  <= ref_nxt;
        end
    end

    assign FLASH_ADDR_OUT      = fa_r;
    assign FLASH_RD_OUT        = frd_r;
    assign FLASH_WR_OUT        = fwr_r;
    assign FLASH_WDATA_OUT     = fwd_r;
    assign FLASH_ERASE_ALL_OUT = fea_r;
    assign FLASH_ERASE_BLK_OUT = feb_r;
    assign FLASH_ERASE_SEL_OUT = fes_r;
    assign RDATA_OUT           = rd_r;
    assign DONE_OUT            = done_r;
    assign REFUSED_OUT         = ref_r;
    assign DBG_RESERVE_OUT     = dbg_r;

    // ******************************************************
    // Assertions
    // ******************************************************
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_B_IN || !CLK_EN_IN);

    sequence seq_cpu_rd_foreign;
        !ext && rq_rd && user && pcr != tgt && !rd_iso_r[pmcp_blk_idx(tgt)];
    endsequence
    sequence seq_zero_refused;
        ##2 RDATA_OUT == 8'h00 && REFUSED_OUT && DONE_OUT;
    endsequence

    a_wr_inhibit_drop: assert property (
        !ext && rq_wr && user && !wr_inh_r[pmcp_blk_idx(tgt)] |=> !FLASH_WR_OUT ##1 REFUSED_OUT)
        else $error("table write into inhibited block reached flash");
    a_iso_read_zero: assert property (
        seq_cpu_rd_foreign |-> ##1 !FLASH_RD_OUT and seq_zero_refused)
        else $error("isolated block leaked data to foreign read");
    a_own_block_read: assert property (
        !ext && rq_rd && user && pcr == tgt |=> FLASH_RD_OUT && FLASH_ADDR_OUT == $past(rq_addr))
        else $error("own block read was not issued to flash");
    a_prot_no_rise: assert property (
        !chip_er && !blk_er |=> (ext_inh_r & ~$past(ext_inh_r)) == 3'h0
            && (wr_inh_r & ~$past(wr_inh_r)) == 3'h0 && (rd_iso_r & ~$past(rd_iso_r)) == 3'h0)
        else $error("protection bit rose without erase");
    a_chip_erase_set: assert property (
        chip_er |=> ext_inh_r == PROT_RST && wr_inh_r == PROT_RST && rd_iso_r == PROT_RST
            && config_write_protect_bit_r && FLASH_ERASE_ALL_OUT)
        else $error("chip erase did not restore protection");
    a_config_write_protect_bit_fw_ro: assert property (
        !ext |=> $stable(config_write_protect_bit_r))
        else $error("firmware changed config write protect");
    a_cfg_wr_blocked: assert property (
        !ext && rq_wr && tgt == RG_CFG && !config_write_protect_bit_r |=> $stable(ext_inh_r) && $stable(wr_inh_r)
            && $stable(rd_iso_r) ##1 REFUSED_OUT)
        else $error("config write passed while protected");
    a_id_readable: assert property (
        rq_rd && tgt == RG_ID |-> ##2 DONE_OUT && !REFUSED_OUT)
        else $error("ID read was refused");
    a_ext_inhibit: assert property (
        ext && rq_rd && user && !ext_inh_r[pmcp_blk_idx(tgt)] |=> !FLASH_RD_OUT ##1 REFUSED_OUT)
        else $error("programmer read of inhibited block passed");

endmodule
`default_nettype wire

// ==== test/pmcp_flash_model.sv ====
// Flash array stand-in answering reads with an address-derived byte.
// Assumes data is taken while the read strobe is high.
`timescale 1ns/1ps
`default_nettype none
module pmcp_flash_model (
    input  wire logic        clk_in,
    input  wire logic [21:0] addr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] junk_r = 8'h11;
    // Changing junk between reads, so stale data never passes for an answer
    always @(posedge clk_in) begin
        junk_r <= junk_r + 8'h5b;
    end
    assign rdata_out = rd_in ? (addr_in[7:0] ^ addr_in[13:6]) : junk_r;
endmodule
`default_nettype wire

// ==== test/program_memory_code_protection_tb.sv ====
// Self-checking bench for the code protection block.
// Assumes the flash model answers in the strobe cycle.
`timescale 1ns/1ps
`default_nettype none
module program_memory_code_protection_tb;
    import pmcp_pkg::*;
    localparam logic [15:0] ID_VAL = 16'hc3a5;  // Arbitrary value
    logic clk = 0, rst_b = 0, dbg_b = 1, trd = 0, twr = 0, pm = 0, prd = 0, pwr = 0;
    logic pce = 0, pbe = 0, frdo, fwr, fea, feb, done, refd, dres, s_ref, s_fl;
    logic [1:0] eblk = 0, fsel;
    logic [21:0] ta = 0, tpc = 0, pa = 0, fa, a;
    logic [7:0] td = 0, pd = 0, frd, rdat, gd, s_d, fwd;
    logic b2k = 0, ce = 1;
    int failures = 0, n_compared = 0;
    pmcp_top #(.DEV_ID(ID_VAL)) dut_u (
        .CLOCK_IN(clk), .RST_B_IN(rst_b), .CLK_EN_IN(ce), .BOOT_2K_IN(b2k),
        .DEBUG_EN_B_IN(dbg_b), .TBL_RD_IN(trd), .TBL_WR_IN(twr), .TBL_ADDR_IN(ta),
        .TBL_PC_IN(tpc), .TBL_WDATA_IN(td), .PGM_MODE_IN(pm), .PGM_RD_IN(prd),
        .PGM_WR_IN(pwr), .PGM_ADDR_IN(pa), .PGM_WDATA_IN(pd), .PGM_CHIP_ERASE_IN(pce),
        .PGM_BLOCK_ERASE_IN(pbe), .PGM_ERASE_BLK_IN(eblk), .FLASH_RDATA_IN(frd),
        .FLASH_ADDR_OUT(fa), .FLASH_RD_OUT(frdo), .FLASH_WR_OUT(fwr), .FLASH_WDATA_OUT(fwd),
        .FLASH_ERASE_ALL_OUT(fea), .FLASH_ERASE_BLK_OUT(feb), .FLASH_ERASE_SEL_OUT(fsel),
        .RDATA_OUT(rdat), .DONE_OUT(done), .REFUSED_OUT(refd), .DBG_RESERVE_OUT(dres));
    pmcp_flash_model flash_u (.clk_in(clk), .addr_in(fa), .rd_in(frdo), .rdata_out(frd));
    initial begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [7:0] fl(input logic [21:0] x);
        return x[7:0] ^ x[13:6];
    endfunction
    task chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // One byte access: strobes looked at in cycle 1, answer in cycle 2
    task acc(input logic p, input logic w, input logic [21:0] ad, input logic [21:0] pc,
             input logic [7:0] d);
        @(posedge clk);
        pm <= p; ta <= ad; pa <= ad; tpc <= pc; td <= d; pd <= d;
        trd <= !p && !w; twr <= !p && w; prd <= p && !w; pwr <= p && w;
        @(posedge clk);
        {trd, twr, prd, pwr} <= 4'h0;
        #1 s_fl = frdo | fwr;
        @(posedge clk);
        #1 s_d = rdat;
        s_ref = refd;
        chk("done", done, 1);
    endtask
    task rchk(input logic p, input logic [21:0] ad, input logic [21:0] pc,
              input logic [7:0] e, input logic r);
        acc(p, 0, ad, pc, 8'h00);
        chk("rd", {s_ref, s_d}, {r, e});
    endtask
    task wchk(input logic p, input logic [21:0] ad, input logic [7:0] d, input logic r,
              input logic f);
        acc(p, 1, ad, 22'h0, d);
        chk("wr", {s_ref, s_fl}, {r, f});
    endtask
    task cfg_img;
        logic [7:0] img [6];
        img = '{8'h03, 8'h40, 8'h03, 8'h60, 8'h03, 8'h40};
        for (int i = 0; i < 6; i++) rchk(0, CFG_EXT_LO + 22'(i), 0, img[i], 0);
    endtask
    task ers(input logic c, input logic [1:0] b);
        @(posedge clk);
        pm <= 1; pce <= c; pbe <= !c; eblk <= b;
        @(posedge clk);
        {pce, pbe} <= 2'h0;
        #1 chk("erase", {fea, feb}, {c, !c});
        if (!c) chk("esel", fsel, b);
    endtask
    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        tally_and_finish;
    end
    initial begin
        void'($urandom(78894));
        repeat (12) @(posedge clk);
        rst_b <= 1;
        cfg_img;
        repeat (20) begin
            a = 22'($urandom_range(16383));
            rchk(0, a, 22'($urandom_range(16383)), fl(a), 0);
        end
        rchk(0, DEVID_LO, 0, ID_VAL[7:0], 0);
        rchk(0, DEVID_HI, 0, ID_VAL[15:8], 0);
        $display("test basic done");
        for (int i = 0; i < 8; i++) begin
            gd = 8'($urandom);
            wchk(i[0], ID_BASE + 22'(i), gd, 0, 0);
            rchk(!i[0], ID_BASE + 22'(i), 0, gd, 0);
        end
        wchk(0, CFG_RDI_LO, 8'hfe, 0, 0);
        rchk(0, 22'h000500, 22'h000100, 8'h00, 1);
        rchk(0, 22'h001234, 22'h001800, fl(22'h001234), 0);
        // 2K boot moves 000400-0007FF into the boot block
        b2k <= 1;
        rchk(0, 22'h000500, 22'h000100, fl(22'h000500), 0);
        rchk(0, 22'h001100, 22'h000700, 8'h00, 1);
        b2k <= 0;
        wchk(0, CFG_RDI_LO, 8'hff, 0, 0);
        rchk(0, CFG_RDI_LO, 0, 8'h02, 0);
        // Clock enable low: a pending config write must not be taken
        @(posedge clk);
        ce <= 0;
        ta <= CFG_RDI_LO;
        td <= 8'h00;
        twr <= 1;
        repeat (3) @(posedge clk);
        twr <= 0;
        ce <= 1;
        #1 chk("frozen", {done, refd}, 2'h0);
        rchk(0, CFG_RDI_LO, 0, 8'h02, 0);
        wchk(0, CFG_WRI_LO, 8'hfd, 0, 0);
        wchk(0, 22'h002abc, 8'($urandom), 1, 0);
        wchk(0, 22'h001abc, 8'($urandom), 0, 1);
        chk("wdata", fwd, td);
        chk("waddr", fa, 22'h001abc);
        wchk(0, CFG_EXT_LO, 8'hfe, 0, 0);
        // Block A is isolated here, so firmware reads it from inside itself
        rchk(0, 22'h001100, 22'h001800, fl(22'h001100), 0);
        rchk(1, 22'h001100, 0, 8'h00, 1);
        rchk(1, ID_END, 0, gd, 0);
        $display("test protect done");
        acc(0, 1, CFG_WRI_HI, 0, 8'h40);
        rchk(0, CFG_WRI_HI, 0, 8'h60, 0);
        wchk(1, CFG_WRI_HI, 8'hdf, 0, 0);
        wchk(0, CFG_RDI_HI, 8'h00, 1, 0);
        rchk(0, CFG_RDI_HI, 0, 8'h40, 0);
        ers(0, 2'h1);
        rchk(0, CFG_EXT_LO, 0, 8'h03, 0);
        // Erase pins are ignored outside programming mode
        @(posedge clk);
        pce <= 1;
        @(posedge clk);
        pce <= 0;
        #1 chk("fw_erase", fea, 1'b0);
        ers(1, 2'h0);
        cfg_img;
        $display("test erase done");
        dbg_b <= 0;
        repeat (2) @(posedge clk);
        #1 chk("dbg", dres, 1);
        wchk(0, 22'h003f00, 8'h00, 1, 0);
        wchk(0, 22'h003dff, 8'h00, 0, 1);
        $display("test debug done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
